/* File: logic/sbs_defs.svh */
// Register offsets, field positions and reset values of the serial buffer/status block
`ifndef SBS_DEFS_SVH
`define SBS_DEFS_SVH
// Register byte offsets
`define SBS_OFS_CTRL      4'h0
`define SBS_OFS_CTRL2     4'h4
`define SBS_OFS_STAT      4'h8
`define SBS_OFS_BUF       4'hC
// First control register fields
`define SBS_CTRL_ON       15
`define SBS_CTRL_ENH      16
`define SBS_CTRL_FRM      31
`define SBS_CTRL_TXM_LO   2
`define SBS_CTRL_RXM_LO   0
// Second control register fields
`define SBS_C2_SGNEXT     15
`define SBS_C2_FRAME_ERR_EVENT_EN   12
`define SBS_C2_ROVEN      11
`define SBS_C2_TUREN      10
`define SBS_C2_IGNORE_RX_OVERFLOW     9
`define SBS_C2_IGNORE_TX_UNDERRUN     8
`define SBS_C2_AUDIO_PROTOCOL_EN      7
`define SBS_C2_MONO       3
`define SBS_C2_FMT_LO     0
// Status register fields
`define SBS_ST_RXCNT_LO   24
`define SBS_ST_TXCNT_LO   16
`define SBS_ST_FRAME_ERROR_FLAG     12
`define SBS_ST_BUSY       11
`define SBS_ST_TUR        8
`define SBS_ST_SHIFTER_EMPTY_FLAG       7
`define SBS_ST_ROV        6
`define SBS_ST_RBE        5
`define SBS_ST_TBE        3
`define SBS_ST_TBF        1
`define SBS_ST_RBF        0
// Interrupt mode encodings
`define SBS_MODE_LAST     2'h0
`define SBS_MODE_ONE      2'h1
`define SBS_MODE_HALF     2'h2
`define SBS_MODE_FULL     2'h3
// Reset values
`define SBS_RST_CTRL      32'h0000_0000
`define SBS_RST_CTRL2     32'h0000_0000
`endif

/* File: logic/sbs_pkg.sv */
// Types shared by the serial buffer/status block
`default_nettype none
package sbs_pkg;
   // Shift engine state, one-hot
   typedef enum logic [2:0] {
      SBS_IDLE  = 3'b001,
      SBS_SHIFT = 3'b010,
      SBS_HALT  = 3'b100
   } sbs_state_t;
endpackage
`default_nettype wire

/* File: logic/sbs_core.sv */
// Serial unit with buffers, interrupt modes, error events, status and audio controls
//
// Chosen here: the register addresses and strobed register access.
`default_nettype none
`include "sbs_defs.svh"
// Operation
// - Transmit interrupt: 11 not full, 10 half empty, 01 empty, 00 all shifted out.
// - Receive interrupt: 11 full, 10 half full, 01 not empty, 00 last word read.
// - Receive words are sign extended to 32 bits when sign extension is set.
// - Frame error gives an error event only with its enable set.
// - Receive overflow gives an error event only with its enable set.
// - Transmit underrun gives an error event only with its enable set.
// - Ignored overflow keeps FIFO contents; otherwise overflow stops serial operation.
// - Ignored underrun sends zeros until data arrives; otherwise underrun stops operation.
// - Audio enable turns on codec support; writable only while module is off.
// - Mono with audio enabled sends each word on left and right channels.
// - Audio format selects PCM, right, left or I2S; writable only while off. Here the format field is only stored and read back.
// - Five-bit receive and transmit element counts report FIFO occupancy.
// - Frame error flag set by hardware in framed mode, cleared by software.
// - Activity flag reads 1 while a transaction is under way.
// - Underrun flag set in framed mode, cleared only by disable then enable.
// - Shifter empty flag reads 1 when the shift register holds nothing.
// - Overflow flag set when a finished word is discarded; software writes 0.
// - Receive FIFO empty flag is 1 when the receive element count is zero.
// - Transmit empty flag resets to 1, set on move, cleared on write.
// - Transmit full flag: standard on write/move, enhanced when pointers meet.
// - Receive full flag: standard on move/read, enhanced when pointers meet.
module sbs_core #(
   parameter int DATA_W = 16,
   parameter int DEPTH  = 8
) (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   // Register port
   input  wire logic [3:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        wr_i,
   input  wire logic        rd_i,
   output logic      [31:0] rdata_o,
   // Serial pins
   input  wire logic        sck_i,
   input  wire logic        sdi_i,
   input  wire logic        ss_n_i,
   input  wire logic        fsync_i,
   output logic             sdo_o,
   output logic             chan_right_o,
   // Interrupt requests
   output logic             tx_irq_o,
   output logic             rx_irq_o,
   output logic             err_irq_o
);
   localparam int PW = $clog2(DEPTH);

   // Refuse shapes the pointers and counts cannot serve
   generate
      if (DEPTH < 2 || DEPTH > 16 || (DEPTH & (DEPTH - 1)) != 0 || DATA_W < 2 || DATA_W > 32)
      begin : g_chk
         $error("sbs_core: DEPTH must be a power of two 2..16, DATA_W 2..32");
      end
   endgenerate

   // ********************************
   // Reset and pin synchronisers
   // ********************************
   logic [1:0] rst_sync_q;
   logic       rst_n;
   logic [3:0] pin_s1_q;
   logic [3:0] pin_s2_q;
   logic       sck_prev_q;
   logic       fs_prev_q;

   // Reset released through two flops
   always_ff @(posedge clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         rst_sync_q <= 2'h0;
      else
         rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // Two flops per pin; only the second stage is looked at
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pin_s1_q   <= 4'h1;
         pin_s2_q   <= 4'h1;
         sck_prev_q <= 1'b0;
         fs_prev_q  <= 1'b0;
      end
      else
      begin
         pin_s1_q   <= {fsync_i, sdi_i, sck_i, ss_n_i};
         pin_s2_q   <= pin_s1_q;
         sck_prev_q <= pin_s2_q[1];
         fs_prev_q  <= pin_s2_q[3];
      end
   end

   logic ss_n, sck_s, sdi_s, fs_s, sck_rise, sck_fall, fs_rise;
   assign ss_n     = pin_s2_q[0];
   assign sck_s    = pin_s2_q[1];
   assign sdi_s    = pin_s2_q[2];
   assign fs_s     = pin_s2_q[3];
   assign sck_rise = sck_s & ~sck_prev_q;
   assign sck_fall = ~sck_s & sck_prev_q;
   assign fs_rise  = fs_s & ~fs_prev_q;

   // ********************************
   // Control registers
   // ********************************
   logic [31:0] ctrl_q;
   logic [31:0] ctrl2_q;
   logic        on_prev_q;
   logic        hit_ctrl, hit_ctrl2, hit_stat, hit_buf;

   assign hit_ctrl  = (addr_i == `SBS_OFS_CTRL);
   assign hit_ctrl2 = (addr_i == `SBS_OFS_CTRL2);
   assign hit_stat  = (addr_i == `SBS_OFS_STAT);
   assign hit_buf   = (addr_i == `SBS_OFS_BUF);

   logic       mod_on, enh, framed, sgnext, frm_en, rov_en, tur_en;
   logic       ign_rov, ign_tur, aud_en, mono;
   logic [1:0] tx_irq_mode, rx_irq_mode;
   assign mod_on      = ctrl_q[`SBS_CTRL_ON];
   assign enh         = ctrl_q[`SBS_CTRL_ENH];
   assign framed      = ctrl_q[`SBS_CTRL_FRM];
   assign tx_irq_mode = ctrl_q[`SBS_CTRL_TXM_LO +: 2];
   assign rx_irq_mode = ctrl_q[`SBS_CTRL_RXM_LO +: 2];
   assign sgnext      = ctrl2_q[`SBS_C2_SGNEXT];
   assign frm_en      = ctrl2_q[`SBS_C2_FRAME_ERR_EVENT_EN];
   assign rov_en      = ctrl2_q[`SBS_C2_ROVEN];
   assign tur_en      = ctrl2_q[`SBS_C2_TUREN];
   assign ign_rov     = ctrl2_q[`SBS_C2_IGNORE_RX_OVERFLOW];
   assign ign_tur     = ctrl2_q[`SBS_C2_IGNORE_TX_UNDERRUN];
   assign aud_en      = ctrl2_q[`SBS_C2_AUDIO_PROTOCOL_EN];
   assign mono        = ctrl2_q[`SBS_C2_MONO];

   // Control writes; audio fields frozen while the module runs
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl_q    <= `SBS_RST_CTRL;
         ctrl2_q   <= `SBS_RST_CTRL2;
         on_prev_q <= 1'b0;
      end
      else
      begin
         on_prev_q <= mod_on;
         if (wr_i && hit_ctrl)
         begin
            ctrl_q <= wdata_i;
         end
         if (wr_i && hit_ctrl2)
         begin
            ctrl2_q[15:8] <= {wdata_i[15], 2'h0, wdata_i[12:8]};
            if (!mod_on)
            begin
               ctrl2_q[`SBS_C2_AUDIO_PROTOCOL_EN] <= wdata_i[`SBS_C2_AUDIO_PROTOCOL_EN];
               ctrl2_q[`SBS_C2_MONO]        <= wdata_i[`SBS_C2_MONO];
               ctrl2_q[`SBS_C2_FMT_LO +: 2] <= wdata_i[`SBS_C2_FMT_LO +: 2];
            end
         end
      end
   end

   // ********************************
   // FIFOs
   // ********************************
   logic [DATA_W-1:0] tx_mem [DEPTH];
   logic [DATA_W-1:0] rx_mem [DEPTH];
   logic [DATA_W-1:0] tx_sh_q, rx_sh_q, last_tx_q;
   logic [PW-1:0]     tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   logic [4:0]        tx_cnt_q, rx_cnt_q, cap;
   logic              tx_push, tx_pop, rx_push, rx_pop;
   logic              tx_full, rx_full, tx_empty, rx_empty;

   // Standard mode behaves as a single holding word
   assign cap      = enh ? 5'(DEPTH) : 5'h1;
   assign tx_full  = (tx_cnt_q == cap);
   assign rx_full  = (rx_cnt_q == cap);
   // transmit empty after move, cleared by a write; receive empty after the last read, cleared by a move
   assign tx_empty = (tx_cnt_q == 5'h0);
   assign rx_empty = (rx_cnt_q == 5'h0);
   assign tx_push  = wr_i && hit_buf && !tx_full;
   assign rx_pop   = rd_i && hit_buf && !rx_empty;

   // Transmit storage and pointers
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_wp_q  <= '0;
         tx_rp_q  <= '0;
         tx_cnt_q <= 5'h0;
      end
      else if (!mod_on)
      begin
         tx_wp_q  <= '0;
         tx_rp_q  <= '0;
         tx_cnt_q <= 5'h0;
      end
      else
      begin
         if (tx_push)
         begin
            tx_mem[tx_wp_q] <= wdata_i[DATA_W-1:0];
            tx_wp_q         <= tx_wp_q + 1'b1;
         end
         if (tx_pop)
            tx_rp_q <= tx_rp_q + 1'b1;
         tx_cnt_q <= tx_cnt_q + 5'(tx_push) - 5'(tx_pop);
      end
   end

   // Receive storage and pointers
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_wp_q  <= '0;
         rx_rp_q  <= '0;
         rx_cnt_q <= 5'h0;
      end
      else if (!mod_on)
      begin
         rx_wp_q  <= '0;
         rx_rp_q  <= '0;
         rx_cnt_q <= 5'h0;
      end
      else
      begin
         if (rx_push)
         begin
            // Last bit joins the word on the same edge that completes it
            rx_mem[rx_wp_q] <= {rx_sh_q[DATA_W-2:0], sdi_s};
            rx_wp_q         <= rx_wp_q + 1'b1;
         end
         if (rx_pop)
            rx_rp_q <= rx_rp_q + 1'b1;
         rx_cnt_q <= rx_cnt_q + 5'(rx_push) - 5'(rx_pop);
      end
   end

   // ********************************
   // Shift engine
   // ********************************
   sbs_pkg::sbs_state_t state_q;
   logic [4:0]          bit_q;
   logic                chan_q;
   logic                start, word_done, underrun, overflow, frame_err, reuse;

   assign start     = framed ? fs_rise : !ss_n;
   assign word_done = (state_q == sbs_pkg::SBS_SHIFT) && sck_rise
                      && (bit_q == 5'(DATA_W - 1));
   // mono repeats the word on the right channel
   assign reuse     = aud_en && mono && chan_q;
   assign underrun  = (state_q == sbs_pkg::SBS_IDLE) && mod_on && start && tx_empty && !reuse;
   assign tx_pop    = (state_q == sbs_pkg::SBS_IDLE) && mod_on && start && !tx_empty && !reuse;
   assign overflow  = word_done && rx_full;
   // a full FIFO keeps its contents either way
   assign rx_push   = word_done && !rx_full;
   assign frame_err = framed && (state_q == sbs_pkg::SBS_SHIFT) && fs_rise && (bit_q != 5'h0);

   // Load, shift and stop
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q   <= sbs_pkg::SBS_IDLE;
         tx_sh_q   <= '0;
         rx_sh_q   <= '0;
         last_tx_q <= '0;
         bit_q     <= 5'h0;
         chan_q    <= 1'b0;
      end
      else if (!mod_on)
      begin
         state_q <= sbs_pkg::SBS_IDLE;
         bit_q   <= 5'h0;
         chan_q  <= 1'b0;
      end
      else
      begin
         case (state_q)
            sbs_pkg::SBS_IDLE:
            begin
               if (start && underrun && !ign_tur)
                  state_q <= sbs_pkg::SBS_HALT;
               else if (start)
               begin
                  tx_sh_q   <= tx_pop ? tx_mem[tx_rp_q] : (reuse ? last_tx_q : '0);
                  last_tx_q <= tx_pop ? tx_mem[tx_rp_q] : last_tx_q;
                  bit_q     <= 5'h0;
                  state_q   <= sbs_pkg::SBS_SHIFT;
               end
            end
            sbs_pkg::SBS_SHIFT:
            begin
               if (frame_err)
                  bit_q <= 5'h0;
               else if (sck_rise)
               begin
                  rx_sh_q <= {rx_sh_q[DATA_W-2:0], sdi_s};
                  bit_q   <= bit_q + 5'h1;
               end
               if (sck_fall)
                  tx_sh_q <= {tx_sh_q[DATA_W-2:0], 1'b0};
               if (word_done)
               begin
                  chan_q <= aud_en ? ~chan_q : 1'b0;
                  state_q <= (rx_full && !ign_rov) ? sbs_pkg::SBS_HALT : sbs_pkg::SBS_IDLE;
               end
            end
            sbs_pkg::SBS_HALT:
               state_q <= sbs_pkg::SBS_HALT;
            default:
               state_q <= sbs_pkg::SBS_IDLE;
         endcase
      end
   end

   // Serial output and channel marker come from flops
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sdo_o        <= 1'b0;
         chan_right_o <= 1'b0;
      end
      else
      begin
         sdo_o        <= (state_q == sbs_pkg::SBS_SHIFT) & tx_sh_q[DATA_W-1];
         chan_right_o <= chan_q;
      end
   end

   // ********************************
   // Status flags
   // ********************************
   logic frm_err_q, rov_q, tur_q, rx_last_q;
   logic stat_wr;
   assign stat_wr = wr_i && hit_stat;

   // Sticky flags; a set in the clearing cycle wins
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
      begin
         frm_err_q <= 1'b0;
         rov_q     <= 1'b0;
         tur_q     <= 1'b0;
      end
      else
      begin
         if (frame_err)
            frm_err_q <= 1'b1;
         else if (stat_wr && !wdata_i[`SBS_ST_FRAME_ERROR_FLAG])
            frm_err_q <= 1'b0;
         // set on discard, software writes 0
         if (overflow)
            rov_q <= 1'b1;
         else if (stat_wr && !wdata_i[`SBS_ST_ROV])
            rov_q <= 1'b0;
         if (underrun && framed)
            tur_q <= 1'b1;
         else if (mod_on && !on_prev_q)
            tur_q <= 1'b0;
      end
   end

   // pulse when the last word is read out
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         rx_last_q <= 1'b0;
      else
         rx_last_q <= rx_pop && (rx_cnt_q == 5'h1);
   end

   always_comb
   begin
      case (tx_irq_mode)
         `SBS_MODE_FULL: tx_irq_o = mod_on && !tx_full;
         `SBS_MODE_HALF: tx_irq_o = mod_on && (({1'b0, tx_cnt_q} << 1) <= {1'b0, cap});
         `SBS_MODE_ONE:  tx_irq_o = mod_on && tx_empty;
         default:        tx_irq_o = mod_on && tx_empty && (state_q != sbs_pkg::SBS_SHIFT);
      endcase
   end

   always_comb
   begin
      case (rx_irq_mode)
         `SBS_MODE_FULL: rx_irq_o = mod_on && rx_full;
         `SBS_MODE_HALF: rx_irq_o = mod_on && (({1'b0, rx_cnt_q} << 1) >= {1'b0, cap});
         `SBS_MODE_ONE:  rx_irq_o = mod_on && !rx_empty;
         default:        rx_irq_o = mod_on && rx_last_q;
      endcase
   end

   // one request from all enabled error events
   // each gated by its own enable
   assign err_irq_o = (frm_err_q & frm_en) | (rov_q & rov_en) | (tur_q & tur_en);

   // ********************************
   // Read port
   // ********************************
   logic [31:0] stat_w;
   logic [31:0] rx_word;

   always_comb
   begin
      stat_w                             = 32'h0000_0000;
      stat_w[`SBS_ST_RXCNT_LO +: 5]      = rx_cnt_q;
      stat_w[`SBS_ST_TXCNT_LO +: 5]      = tx_cnt_q;
      stat_w[`SBS_ST_FRAME_ERROR_FLAG]             = frm_err_q;
      stat_w[`SBS_ST_BUSY]               = (state_q == sbs_pkg::SBS_SHIFT) || !tx_empty;
      stat_w[`SBS_ST_TUR]                = tur_q;
      stat_w[`SBS_ST_SHIFTER_EMPTY_FLAG]               = (state_q != sbs_pkg::SBS_SHIFT);
      stat_w[`SBS_ST_ROV]                = rov_q;
      stat_w[`SBS_ST_RBE]                = rx_empty;
      stat_w[`SBS_ST_TBE]                = tx_empty;
      stat_w[`SBS_ST_TBF]                = tx_full;
      stat_w[`SBS_ST_RBF]                = rx_full;
   end

   assign rx_word = sgnext ? 32'($signed(rx_mem[rx_rp_q])) : 32'(rx_mem[rx_rp_q]);

   // Read data stands in the cycle after the strobe only
   always_ff @(posedge clk_i or negedge rst_n)
   begin
      if (!rst_n)
         rdata_o <= 32'h0000_0000;
      else if (!rd_i)
         rdata_o <= 32'h0000_0000;
      else if (hit_ctrl)
         rdata_o <= ctrl_q;
      else if (hit_ctrl2)
         rdata_o <= ctrl2_q;
      else if (hit_stat)
         rdata_o <= stat_w;
      else if (hit_buf)
         rdata_o <= rx_empty ? 32'h0000_0000 : rx_word;
      else
         rdata_o <= 32'h0000_0000;
   end

endmodule
`default_nettype wire

/* File: bench/sbs_core_monitor.sv */
// Port-level checker of the serial buffer/status block, with its bind
`default_nettype none
`include "sbs_defs.svh"
module sbs_core_monitor #(
   parameter int DATA_W = 16,
   parameter int DEPTH  = 8
) (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        nrst_i,
   // Register port
   input wire logic [3:0]  addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic        wr_i,
   input wire logic        rd_i,
   input wire logic [31:0] rdata_o,
   // Serial pins
   input wire logic        sck_i,
   input wire logic        sdi_i,
   input wire logic        ss_n_i,
   input wire logic        fsync_i,
   input wire logic        sdo_o,
   input wire logic        chan_right_o,
   // Interrupt requests
   input wire logic        tx_irq_o,
   input wire logic        rx_irq_o,
   input wire logic        err_irq_o
);
   logic st_q;
   logic c2_q;
   logic enh_q;
   int   cap;
   // ****************
   // Helper state
   // ****************
   // Which register the previous read strobe addressed
   always_ff @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
      begin
         st_q <= 1'b0;
         c2_q <= 1'b0;
      end
      else
      begin
         st_q <= rd_i && addr_i == `SBS_OFS_STAT;
         c2_q <= rd_i && addr_i == `SBS_OFS_CTRL2;
      end
   // Buffer mode decides what full means: one word or the whole FIFO
   always_ff @(posedge clk_i or negedge nrst_i)
      if (!nrst_i)
         enh_q <= 1'b0;
      else if (wr_i && addr_i == `SBS_OFS_CTRL)
         enh_q <= wdata_i[`SBS_CTRL_ENH];
   assign cap = enh_q ? DEPTH : 1;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!nrst_i);
   stat_reserved_a: assert property (st_q |-> (rdata_o & 32'hE0E0_E614) == 32'h0)
      else $error("status reserved bits not zero");
   count_range_a: assert property (st_q |-> rdata_o[28:24] <= DEPTH && rdata_o[20:16] <= DEPTH)
      else $error("element count above depth");
   rx_empty_a: assert property (st_q |-> rdata_o[`SBS_ST_RBE] == (rdata_o[28:24] == 5'h0))
      else $error("rx empty flag disagrees with count");
   tx_empty_a: assert property (st_q |-> rdata_o[`SBS_ST_TBE] == (rdata_o[20:16] == 5'h0))
      else $error("tx empty flag disagrees with count");
   tx_full_a: assert property (st_q |-> rdata_o[`SBS_ST_TBF] == (rdata_o[20:16] == cap))
      else $error("tx full flag disagrees with count");
   rx_full_a: assert property (st_q |-> rdata_o[`SBS_ST_RBF] == (rdata_o[28:24] == cap))
      else $error("rx full flag disagrees with count");
   ctrl2_reserved_a: assert property (c2_q |-> (rdata_o & 32'hFFFF_6074) == 32'h0)
      else $error("control two reserved bits not zero");
   err_masked_a: assert property (wr_i && addr_i == `SBS_OFS_CTRL2 && wdata_i[12:10] == 3'h0
      |=> !err_irq_o)
      else $error("error request with all events disabled");
   tx_irq_off_a: assert property (wr_i && addr_i == `SBS_OFS_CTRL && !wdata_i[`SBS_CTRL_ON]
      |=> !tx_irq_o [*2])
      else $error("tx request while module off");
endmodule
bind sbs_core sbs_core_monitor #(.DATA_W(DATA_W), .DEPTH(DEPTH)) u_sbs_mon (
   .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
   .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck_i), .sdi_i(sdi_i), .ss_n_i(ss_n_i),
   .fsync_i(fsync_i), .sdo_o(sdo_o), .chan_right_o(chan_right_o), .tx_irq_o(tx_irq_o),
   .rx_irq_o(rx_irq_o), .err_irq_o(err_irq_o));
`default_nettype wire

/* File: bench/sbs_peer.sv */
// Behavioural serial master that clocks words through the block
`default_nettype none
module sbs_peer #(
   parameter int W = 16
) (
   // Serial pins toward the block
   output logic     sck_o,
   output logic     sdi_o,
   output logic     ss_n_o,
   output logic     fsync_o,
   input wire logic sdo_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle: clock parked low between frames, nothing selected
   initial
   begin
      sck_o   = 1'b0;
      sdi_o   = 1'b0;
      ss_n_o  = 1'b1;
      fsync_o = 1'b0;
   end
   // One word MSB first at 320 ns a bit; brk raises sync again mid-word
   task automatic xfer(input logic [W-1:0] d, input logic frm, input logic brk,
                       output logic [W-1:0] q);
      #13;
      ss_n_o  = frm;
      fsync_o = frm;
      #320;
      for (int i = W - 1; i >= 0; i--)
      begin
         sdi_o = d[i];
         #160;
         sck_o   = 1'b1;
         q[i]    = sdo_i;
         fsync_o = brk && i == W / 2;
         // Select lifts with the last rise: an idle block restarts while it stays low
         if (i == 0)
            ss_n_o = 1'b1;
         #160;
         sck_o = 1'b0;
      end
      #160;
      ss_n_o = 1'b1;
      // A released line must not keep showing the last bit
      sdi_o = ~sdi_o;
      #200;
   endtask
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench of the serial buffer/status block
`default_nettype none
`include "sbs_defs.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DP = 8;
   localparam logic [3:0] A_CTL = `SBS_OFS_CTRL;
   localparam logic [3:0] A_C2 = `SBS_OFS_CTRL2;
   localparam logic [3:0] A_ST = `SBS_OFS_STAT;
   localparam logic [3:0] A_BUF = `SBS_OFS_BUF;
   logic        clk_i = 1'b0;
   logic        nrst_i = 1'b0;
   logic        wr_i = 1'b0;
   logic        rd_i = 1'b0;
   logic [3:0]  addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic [31:0] v;
   logic [31:0] r;
   logic [15:0] got;
   logic [15:0] txw [0:DP];
   logic [15:0] rxw [0:DP];
   wire logic [31:0] rdata_o;
   wire logic   sck, sdi, ss_n, fsync, sdo, chan, tx_irq, rx_irq, err_irq;
   int          mismatches = 0;
   int          total_checks = 0;
   int          cyc = 0;
   integer      seed = 32'h2384;
   sbs_core #(.DEPTH(DP)) u_sbs_core (
      .clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
      .rd_i(rd_i), .rdata_o(rdata_o), .sck_i(sck), .sdi_i(sdi), .ss_n_i(ss_n),
      .fsync_i(fsync), .sdo_o(sdo), .chan_right_o(chan), .tx_irq_o(tx_irq),
      .rx_irq_o(rx_irq), .err_irq_o(err_irq));
   sbs_peer u_sbs_peer (.sck_o(sck), .sdi_o(sdi), .ss_n_o(ss_n), .fsync_o(fsync), .sdo_i(sdo));
   // 25 MHz clock
   always #20 clk_i = ~clk_i;
   // Ceiling far above the few thousand cycles the sequence needs
   always @(posedge clk_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         mismatches++;
         finish_test();
      end
   end
   // Status expected when idle in enhanced mode, counts and extra flags given
   function automatic logic [31:0] exp_st(input int rc, input int tc, input logic [31:0] f);
      return f | 32'h80 | (32'(rc) << 24) | (32'(tc) << 16)
         | {26'h0, rc == 0, 1'b0, tc == 0, 1'b0, tc == DP, rc == DP};
   endfunction
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      total_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask
   // Write strobe for one cycle, then wait to mid-cycle so results have settled
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      wr_i <= 1'b1;
      addr_i <= a;
      wdata_i <= d;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(negedge clk_i);
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge clk_i);
      rd_i <= 1'b1;
      addr_i <= a;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
   endtask
   task automatic chk_rd(input logic [3:0] a, input logic [31:0] e, input string n);
      logic [31:0] t;
      rd(a, t);
      chk(n, e, t);
   endtask
   task automatic finish_test();
      if (mismatches == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // Main sequence
   initial
   begin
      repeat (4) @(posedge clk_i);
      nrst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk_rd(A_CTL, 32'h0, "ctrl");
      chk_rd(A_C2, 32'h0, "ctrl2");
      chk_rd(A_ST, exp_st(0, 0, 32'h0), "stat reset");
      chk_rd(4'h2, 32'h0, "unmapped");
      v = $random(seed);
      wr(A_C2, v);
      chk_rd(A_C2, v & 32'h9F8B, "ctrl2 off");
      wr(A_CTL, 32'h8000);
      chk("tx irq idle", 32'h1, 32'(tx_irq));
      wr(A_C2, ~v);
      chk_rd(A_C2, (~v & 32'h9F00) | (v & 32'h8B), "ctrl2 on");
      wr(A_CTL, 32'h0);
      wr(A_C2, 32'h8B00);
      wr(A_CTL, 32'h0001_800F);
      // Fill past capacity; the extra word is dropped
      for (int k = 0; k <= DP; k++)
      begin
         txw[k] = 16'($random(seed));
         wr(A_BUF, {16'h0, txw[k]});
         if (k == 3)
            for (int m = 0; m < 4; m++)
            begin
               wr(A_CTL, 32'h0001_8003 | (m << 2));
               chk("tx irq half", 32'(m >= 2), 32'(tx_irq));
            end
      end
      // Words waiting to go out count as activity
      chk_rd(A_ST, exp_st(0, DP, 32'h800), "stat tx full");
      chk("tx irq full", 32'h0, 32'(tx_irq));
      // Nine words each way: the last underruns and overflows, both ignored
      for (int k = 0; k <= DP; k++)
      begin
         rxw[k] = 16'($random(seed));
         fork
            u_sbs_peer.xfer(rxw[k], 1'b0, 1'b0, got);
            begin
               repeat (40) @(posedge clk_i);
               rd(A_ST, r);
               chk("busy", 32'h800, r & 32'h800);
            end
         join
         chk("sent", {16'h0, k < DP ? txw[k] : 16'h0}, {16'h0, got});
      end
      repeat (10) @(posedge clk_i);
      chk_rd(A_ST, exp_st(DP, 0, 32'h40), "stat ovf");
      chk("err ovf", 32'h1, 32'(err_irq));
      wr(A_C2, 32'h8300);
      chk("err masked", 32'h0, 32'(err_irq));
      wr(A_C2, 32'h8B00);
      for (int m = 0; m < 4; m++)
      begin
         wr(A_CTL, 32'h0001_800C | m);
         chk("rx irq full", 32'(m != 0), 32'(rx_irq));
      end
      // Drain in order, sign extended; a read of the empty FIFO gives zero
      for (int k = 0; k <= DP; k++)
      begin
         rd(A_BUF, r);
         chk("rx word", k < DP ? {{16{rxw[k][15]}}, rxw[k]} : 32'h0, r);
         if (k == 0)
            chk("rx irq", 32'h0, 32'(rx_irq));
      end
      chk_rd(A_ST, exp_st(0, 0, 32'h40), "stat drained");
      wr(A_ST, 32'h0);
      chk_rd(A_ST, exp_st(0, 0, 32'h0), "stat clear");
      chk("err off", 32'h0, 32'(err_irq));
      // Framed word with nothing to send and a second sync inside it
      wr(A_CTL, 32'h0);
      wr(A_C2, 32'h1100);
      wr(A_CTL, 32'h8001_8000);
      u_sbs_peer.xfer(16'($random(seed)), 1'b1, 1'b1, got);
      chk("zeros", 32'h0, {16'h0, got});
      repeat (10) @(posedge clk_i);
      rd(A_ST, r);
      chk("frame flags", 32'h1100, r & 32'h1100);
      chk("err frame", 32'h1, 32'(err_irq));
      wr(A_ST, 32'h0);
      rd(A_ST, r);
      chk("flags clear", 32'h100, r & 32'h1100);
      chk("err tur off", 32'h0, 32'(err_irq));
      wr(A_C2, 32'h1500);
      chk("err tur", 32'h1, 32'(err_irq));
      wr(A_CTL, 32'h0);
      wr(A_CTL, 32'h8001_8000);
      rd(A_ST, r);
      chk("tur cleared", 32'h0, r & 32'h1100);
      // Mono audio: one written word goes out on both channels
      wr(A_CTL, 32'h0);
      wr(A_C2, 32'h0188);
      wr(A_CTL, 32'h0001_8000);
      wr(A_BUF, {16'h0, txw[0]});
      for (int k = 0; k < 2; k++)
      begin
         u_sbs_peer.xfer(rxw[k], 1'b0, 1'b0, got);
         chk("mono word", {16'h0, txw[0]}, {16'h0, got});
         chk("channel", 32'(k == 0), 32'(chan));
      end
      finish_test();
   end
endmodule
`default_nettype wire
